//--- rtl/lfp_limit_flags.sv
/*
  limit violation flags and multifunction pin configuration, reached over
  the serial link; assumes the conversion engine drives the event inputs on
  CLK_SYS, and that the serial pins come from another clock domain
*/
`include "lfp_params.svh"

// How it works
// RL1 - pin select 0 drives general output zero; 1 shows alert or busy
// RL2 - bit 3 is status polarity when selected, else output zero level
// RL3 - bit 2 directly drives the second general output; resets to zero
// RL4 - two-bit power field switches bias generator and reference on or off
// RL5 - two flags per channel mark upper and lower limit crossings
// RL6 - channel n low flag at bit 2n+1, high flag at bit 2n
// RL7 - flags accumulate until the host reads the status word
// RL8 - status word is read only; writes leave it unchanged
// RL9 - reading status clears it on second serial clock of readout frame
// RL10 - conversion before readout sends result instead, flags kept
// RL11 - flags of channels not implemented always read zero
// RL12 - busy selection works only with pin select 1, else reads zero
// RL13 - latch mode clears pin alert only by read or soft reset
module lfp_limit_flags
  import lfp_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  // conversion engine
  input wire logic CONV_DONE,
  input wire logic [15:0] CONV_RESULT,
  input wire logic CONV_BUSY,
  input wire logic [7:0] VIOL_HI,
  input wire logic [7:0] VIOL_LO,
  input wire logic HYST_CLEAR,
  input wire logic SOFT_RST,
  // pins and power
  output logic MF_PIN_O,
  output logic MF_PIN_OE,
  output logic OUT1_PIN,
  output logic BIAS_ON,
  output logic REF_ON
);

  // synchronisers: sclk, cs_n, sdi
  logic [2:0] sync1, sync2, sync3;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low, sdi_s;

  lfp_cfg_s cfg, next_cfg;
  logic [15:0] flags, next_flags;
  logic alert, next_alert;
  logic [15:0] rx, next_rx, tx, next_tx;
  logic [4:0] bit_cnt, next_bit_cnt;
  lfp_src_e pend, next_pend, src, next_src;
  logic conv_seen, next_conv_seen;
  logic [15:0] last_result, next_last_result;
  logic mf_o, next_mf_o;

  logic [15:0] impl_mask, events;
  logic clr, take, busy_eff, active;
  lfp_cmd_s cmd;
  logic [7:0] cfg_rd;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sync3 <= 3'h7;
    end else begin
      sync1 <= {SCLK, CS_N, SDI};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign sclk_rise = sync2[2] & ~sync3[2];
  assign sclk_fall = ~sync2[2] & sync3[2];
  assign cs_fall = ~sync2[1] & sync3[1];
  assign cs_rise = sync2[1] & ~sync3[1];
  assign cs_low = ~sync2[1];
  assign sdi_s = sync2[0];

  // flag placement and channel count mask
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      assign impl_mask[2*g+1:2*g] = (g < NUM_CH) ? 2'h3 : 2'h0; // RL11
      assign events[2*g] = VIOL_HI[g]; // RL6
      assign events[2*g+1] = VIOL_LO[g]; // RL6
    end
  endgenerate

  assign cmd = lfp_cmd_s'(rx);
  assign take = cs_rise && (bit_cnt == `LFP_FRAME_BITS);
  // second serial clock rise of a frame that shifts the flags out
  assign clr = sclk_rise && cs_low && (bit_cnt == `LFP_CLR_RISE)
    && (src == LFP_SRC_VIOL); // RL9
  assign busy_eff = cfg.busy_sel & cfg.pin_function_select; // RL12
  assign cfg_rd = {cfg.sticky, cfg.drive_cmos, busy_eff,
    cfg.pin_function_select, cfg.pin_polarity_or_out0_level,
    cfg.general_output_one_level, cfg.pdown}; // RL12
  assign active = busy_eff ? CONV_BUSY : alert;

  // flags and pin alert state
  always_comb begin
    next_flags = flags;
    next_alert = alert;
    if (clr || SOFT_RST) begin
      next_flags = `LFP_VIOL_RESET; // RL9
      next_alert = 1'b0; // RL13
    end
    if (!cfg.sticky && HYST_CLEAR) begin
      next_alert = 1'b0; // RL13
    end
    // set wins over clear; earlier flags stay
    next_flags = next_flags | (events & impl_mask); // RL5 RL7 RL11
    if (|(events & impl_mask)) begin
      next_alert = 1'b1;
    end
  end

  // serial frame, command decode, configuration
  always_comb begin
    next_cfg = cfg;
    next_rx = rx;
    next_tx = tx;
    next_bit_cnt = bit_cnt;
    next_pend = pend;
    next_src = src;
    next_conv_seen = conv_seen | CONV_DONE;
    next_last_result = CONV_DONE ? CONV_RESULT : last_result;
    if (cs_fall) begin
      next_bit_cnt = 5'h00;
      case (pend)
        LFP_SRC_VIOL: begin
          if (conv_seen || CONV_DONE) begin
            next_tx = CONV_DONE ? CONV_RESULT : last_result; // RL10
            next_src = LFP_SRC_RESULT; // RL10
          end else begin
            next_tx = flags & impl_mask; // RL11
            next_src = LFP_SRC_VIOL;
          end
        end
        LFP_SRC_CFG: begin
          next_tx = {8'h00, cfg_rd};
          next_src = LFP_SRC_CFG;
        end
        LFP_SRC_RESULT: begin
          next_tx = CONV_DONE ? CONV_RESULT : last_result;
          next_src = LFP_SRC_RESULT;
        end
        default: begin
          next_tx = 16'h0000;
          next_src = LFP_SRC_NONE;
        end
      endcase
    end else if (sclk_rise && cs_low) begin
      next_rx = {rx[14:0], sdi_s};
      if (bit_cnt != 5'h1F) begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
    end else if (sclk_fall && cs_low) begin
      next_tx = {tx[14:0], 1'b0};
    end
    if (cs_rise) begin
      next_src = LFP_SRC_NONE;
      next_pend = LFP_SRC_RESULT;
      if (take && cmd.wr) begin
        if (cmd.addr == `LFP_ADDR_CONFIG) begin
          next_cfg = lfp_cfg_s'(cmd.data[7:0]); // RL3 RL4
        end
        // writes to the flag word are dropped
      end else if (take) begin // RL8
        if (cmd.addr == `LFP_ADDR_CONFIG) begin
          next_pend = LFP_SRC_CFG;
        end else if (cmd.addr == `LFP_ADDR_VIOL) begin
          next_pend = LFP_SRC_VIOL;
          next_conv_seen = 1'b0;
        end else begin
          next_pend = LFP_SRC_NONE;
        end
      end
    end
  end

  // multifunction pin level
  always_comb begin
    if (cfg.pin_function_select) begin
      next_mf_o = cfg.pin_polarity_or_out0_level ? active : ~active; // RL2
    end else begin
      next_mf_o = cfg.pin_polarity_or_out0_level; // RL1
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg <= lfp_cfg_s'(`LFP_CFG_RESET);
      flags <= `LFP_VIOL_RESET;
      alert <= 1'b0;
      rx <= 16'h0000;
      tx <= 16'h0000;
      bit_cnt <= 5'h00;
      pend <= LFP_SRC_RESULT;
      src <= LFP_SRC_NONE;
      conv_seen <= 1'b0;
      last_result <= 16'h0000;
      mf_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      flags <= next_flags;
      alert <= next_alert;
      rx <= next_rx;
      tx <= next_tx;
      bit_cnt <= next_bit_cnt;
      pend <= next_pend;
      src <= next_src;
      conv_seen <= next_conv_seen;
      last_result <= next_last_result;
      mf_o <= next_mf_o;
    end
  end

  assign SDO = tx[15];
  assign MF_PIN_O = mf_o;
  // open drain drives only the low level
  assign MF_PIN_OE = cfg.drive_cmos | ~mf_o;
  assign OUT1_PIN = cfg.general_output_one_level; // RL3
  assign BIAS_ON = cfg.pdown[1]; // RL4
  assign REF_ON = cfg.pdown[0]; // RL4

  // checks
  property p_out0_level;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !cfg.pin_function_select |=>
      MF_PIN_O == $past(cfg.pin_polarity_or_out0_level);
  endproperty
  a_out0_level: assert property (p_out0_level) // RL1
    else $error("output zero level wrong");

  property p_low_polarity;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (cfg.pin_function_select && !busy_eff && alert
      && !cfg.pin_polarity_or_out0_level) |=> !MF_PIN_O;
  endproperty
  a_low_polarity: assert property (p_low_polarity) // RL2
    else $error("active low alert not low");

  property p_out1_write;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (take && cmd.wr && cmd.addr == `LFP_ADDR_CONFIG) |=>
      OUT1_PIN == $past(rx[`LFP_CFG_OUT1]);
  endproperty
  a_out1_write: assert property (p_out1_write) // RL3
    else $error("second output not from write");

  property p_power_write;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (take && cmd.wr && cmd.addr == `LFP_ADDR_CONFIG) |=>
      {BIAS_ON, REF_ON} == $past(rx[1:0]);
  endproperty
  a_power_write: assert property (p_power_write) // RL4
    else $error("power mode not from write");

  property p_hi0_set;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    VIOL_HI[0] |=> flags[0];
  endproperty
  a_hi0_set: assert property (p_hi0_set) // RL5
    else $error("channel 0 high flag not set");

  property p_lo1_place;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (NUM_CH > 1 && VIOL_LO[1] && !VIOL_HI[1] && !flags[2]) |=>
      flags[3] && !flags[2];
  endproperty
  a_lo1_place: assert property (p_lo1_place) // RL6
    else $error("channel 1 low flag misplaced");

  property p_accumulate;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !(clr || SOFT_RST) |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_accumulate: assert property (p_accumulate) // RL7 RL8
    else $error("flag lost without read");

  property p_read_clear;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (clr && !(|events)) |=> flags == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) // RL9
    else $error("flags not cleared by read");

  property p_conv_wins;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (cs_fall && pend == LFP_SRC_VIOL && conv_seen) |=>
      src == LFP_SRC_RESULT
      && tx == ($past(CONV_DONE) ? $past(CONV_RESULT) : $past(last_result));
  endproperty
  a_conv_wins: assert property (p_conv_wins) // RL10
    else $error("result not sent after conversion");

  property p_unimpl_zero;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (flags & ~impl_mask) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // RL11
    else $error("unimplemented channel flag set");

  property p_busy_reads_zero;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (cs_fall && pend == LFP_SRC_CFG && !cfg.pin_function_select) |=>
      !tx[`LFP_CFG_BUSY];
  endproperty
  a_busy_reads_zero: assert property (p_busy_reads_zero) // RL12
    else $error("busy bit read back as one");

  property p_sticky_hold;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (cfg.sticky && alert && !clr && !SOFT_RST) |=> alert;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) // RL13
    else $error("latched alert dropped");

  c_read_clear: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    clr && flags != 16'h0000);
  c_conv_wins: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    cs_fall && pend == LFP_SRC_VIOL && conv_seen);
  c_cfg_write: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    take && cmd.wr && cmd.addr == `LFP_ADDR_CONFIG);

endmodule : lfp_limit_flags

//--- rtl/lfp_params.svh
/*
  offsets, field positions, reset values and counts of the limit flag and
  pin configuration block; assumes inclusion by the block and its bench
*/
`ifndef LFP_PARAMS_SVH
`define LFP_PARAMS_SVH

// register indices on the serial link
`define LFP_ADDR_CONFIG 5'h02
`define LFP_ADDR_VIOL 5'h03

// configuration field positions
`define LFP_CFG_STICKY 7
`define LFP_CFG_DRIVE 6
`define LFP_CFG_BUSY 5
`define LFP_CFG_PINSEL 4
`define LFP_CFG_POL 3
`define LFP_CFG_OUT1 2
`define LFP_CFG_PD_HI 1
`define LFP_CFG_PD_LO 0

// reset values
`define LFP_CFG_RESET 8'hC0
`define LFP_VIOL_RESET 16'h0000

// frame counts
`define LFP_FRAME_BITS 5'h10
`define LFP_CLR_RISE 5'h01

`endif

//--- rtl/lfp_pkg.sv
/*
  types of the limit flag and pin configuration block;
  assumes lfp_params.svh holds the numeric constants
*/
package lfp_pkg;

  // what the next frame shifts out
  typedef enum logic [1:0] {
    LFP_SRC_RESULT = 2'b00,
    LFP_SRC_VIOL = 2'b01,
    LFP_SRC_CFG = 2'b10,
    LFP_SRC_NONE = 2'b11
  } lfp_src_e;

  // command word taken at the end of a frame
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic [9:0] data;
  } lfp_cmd_s;

  // low part of the operating configuration
  typedef struct packed {
    logic sticky;
    logic drive_cmos;
    logic busy_sel;
    logic pin_function_select;
    logic pin_polarity_or_out0_level;
    logic general_output_one_level;
    logic [1:0] pdown;
  } lfp_cfg_s;

endpackage : lfp_pkg

//--- bench/lfp_spi_host.sv
/*
  host side of the serial link: frames of 16 bits, msb first;
  assumes it is called at a falling edge of clk_sys
*/
module lfp_spi_host (
  // clock
  input wire logic clk_sys,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cyc

  // 80 ns link clock, idle low between frames
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      wait_cyc(4);
      rx[i] = sdo;
      sclk = 1'b1;
      wait_cyc(4);
      sclk = 1'b0;
    end
    wait_cyc(4);
    cs_n = 1'b1;
    // released data line shows the inverse of its last bit
    sdi = ~sdi;
    wait_cyc(8);
  endtask : frame
endmodule : lfp_spi_host

//--- bench/test_lfp_limit_flags.sv
/*
  self-checking bench of the limit flag and pin block;
  assumes lfp_spi_host as the serial host and four channels built
*/
`include "lfp_params.svh"

module test_lfp_limit_flags;
  import lfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, arst_n, sclk, cs_n, sdi, sdo, conv_done, conv_busy;
  logic hyst_clear, soft_rst, mf_pin_o, mf_pin_oe, out1_pin, bias_on, ref_on;
  logic [15:0] conv_result, rx, d;
  logic [7:0] viol_hi, viol_lo;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  lfp_limit_flags #(.NUM_CH(4)) u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .CONV_DONE(conv_done),
    .CONV_RESULT(conv_result), .CONV_BUSY(conv_busy), .VIOL_HI(viol_hi),
    .VIOL_LO(viol_lo), .HYST_CLEAR(hyst_clear), .SOFT_RST(soft_rst),
    .MF_PIN_O(mf_pin_o), .MF_PIN_OE(mf_pin_oe), .OUT1_PIN(out1_pin),
    .BIAS_ON(bias_on), .REF_ON(ref_on));

  lfp_spi_host u_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      report_and_stop;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_cfg(input lfp_cfg_s c);
    u_host.frame({`LFP_ADDR_CONFIG, 1'b1, 2'b00, c}, rx);
  endtask : wr_cfg

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    u_host.frame({a, 1'b0, 10'h000}, rx);
    u_host.frame({5'h1F, 1'b0, 10'h000}, v);
  endtask : rd

  // one-cycle event pulses, then time for the pin to follow
  task automatic ev(input logic [7:0] hi, input logic [7:0] lo,
                    input logic hy, input logic sr);
    viol_hi = hi;
    viol_lo = lo;
    hyst_clear = hy;
    soft_rst = sr;
    @(negedge clk_sys);
    viol_hi = 8'h00;
    viol_lo = 8'h00;
    hyst_clear = 1'b0;
    soft_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : ev

  task automatic t_reset;
    check({11'h0, out1_pin, bias_on, ref_on, mf_pin_o, mf_pin_oe},
          16'h0001);
    rd(`LFP_ADDR_CONFIG, d);
    check(d, 16'h00C0);
    rd(`LFP_ADDR_VIOL, d);
    check(d, 16'h0000);
  endtask : t_reset

  task automatic t_power;
    lfp_cfg_s c;
    for (int i = 0; i < 4; i++) begin
      c = lfp_cfg_s'({6'b110000, 2'(i)});
      c.general_output_one_level = i[0];
      wr_cfg(c);
      check({13'h0, out1_pin, bias_on, ref_on}, {13'h0, i[0], 2'(i)});
      rd(`LFP_ADDR_CONFIG, d);
      check(d, {8'h00, c});
    end
  endtask : t_power

  task automatic t_pin;
    wr_cfg(8'hC0);
    check({15'h0, mf_pin_o}, 16'h0000);
    wr_cfg(8'hE8);
    check({15'h0, mf_pin_o}, 16'h0001);
    rd(`LFP_ADDR_CONFIG, d);
    check(d, 16'h00C8);
    wr_cfg(8'hD0);
    check({15'h0, mf_pin_o}, 16'h0001);
    ev(8'h02, 8'h00, 1'b0, 1'b0);
    check({15'h0, mf_pin_o}, 16'h0000);
    ev(8'h00, 8'h00, 1'b1, 1'b0);
    check({15'h0, mf_pin_o}, 16'h0000);
    ev(8'h00, 8'h00, 1'b0, 1'b1);
    check({15'h0, mf_pin_o}, 16'h0001);
    wr_cfg(8'h58);
    check({15'h0, mf_pin_o}, 16'h0000);
    ev(8'h00, 8'h04, 1'b0, 1'b0);
    check({15'h0, mf_pin_o}, 16'h0001);
    ev(8'h00, 8'h00, 1'b1, 1'b0);
    check({15'h0, mf_pin_o}, 16'h0000);
    wr_cfg(8'h08);
    check({14'h0, mf_pin_o, mf_pin_oe}, 16'h0002);
    wr_cfg(8'h78);
    conv_busy = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({15'h0, mf_pin_o}, 16'h0001);
    conv_busy = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({15'h0, mf_pin_o}, 16'h0000);
    rd(`LFP_ADDR_CONFIG, d);
    check(d, 16'h0078);
    rd(`LFP_ADDR_VIOL, d);
    check(d, 16'h0020);
  endtask : t_pin

  task automatic t_flags;
    ev(8'h41, 8'h08, 1'b0, 1'b0);
    ev(8'h00, 8'h02, 1'b0, 1'b0);
    u_host.frame({`LFP_ADDR_VIOL, 1'b1, 10'h3FF}, rx);
    rd(`LFP_ADDR_VIOL, d);
    check(d, 16'h0089);
    rd(`LFP_ADDR_VIOL, d);
    check(d, 16'h0000);
  endtask : t_flags

  task automatic t_conv;
    ev(8'h04, 8'h00, 1'b0, 1'b0);
    u_host.frame({`LFP_ADDR_VIOL, 1'b0, 10'h000}, rx);
    conv_result = 16'hA5C3;
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    u_host.frame({5'h1F, 1'b0, 10'h000}, d);
    check(d, 16'hA5C3);
    rd(`LFP_ADDR_VIOL, d);
    check(d, 16'h0010);
  endtask : t_conv

  initial begin
    {arst_n, conv_done, conv_busy, hyst_clear, soft_rst} = 5'h00;
    conv_result = 16'h0000;
    viol_hi = 8'h00;
    viol_lo = 8'h00;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset;
    t_power;
    t_pin;
    t_flags;
    t_conv;
    report_and_stop;
  end
endmodule : test_lfp_limit_flags
